// ### design/irq_ctrl_pkg.sv
// Shared constants and types for the interrupt pin and vector controller
package irq_ctrl_pkg;

  // ==========================================================================
  // Vector table
  localparam int          VEC_COUNT        = 32;
  localparam int          VEC_NUM_W        = 5;
  localparam logic [15:0] VEC_TOP_ADDR     = 16'hfffe;
  localparam logic [15:0] VEC_BOTTOM_ADDR  = 16'hffc0;
  localparam logic [4:0]  VEC_RESET        = 5'h00;
  localparam logic [4:0]  VEC_PIN          = 5'h02;
  localparam logic [4:0]  VEC_TIMER2_OVF   = 5'h0e;
  localparam logic [4:0]  VEC_PERIODIC     = 5'h19;
  localparam logic [4:0]  VEC_UNUSED_FIRST = 5'h1a;
  // Vectors that can never request: reset and the unused block 26..31
  localparam logic [31:0] VEC_USABLE_MASK  = 32'h03ff_fffe;

  // ==========================================================================
  // CPU frame
  localparam logic [15:0] SP_RESET         = 16'h00ff;
  localparam int          CCR_MASK_BIT     = 3;
  localparam logic [1:0]  FILL_BYTES       = 2'h3;

  typedef enum {
    ST_IDLE,
    ST_PUSH_PCL,
    ST_PUSH_PCH,
    ST_PUSH_X,
    ST_PUSH_A,
    ST_PUSH_CCR,
    ST_VEC_HI,
    ST_VEC_LO,
    ST_POP_CCR,
    ST_POP_A,
    ST_POP_X,
    ST_POP_PCH,
    ST_POP_PCL,
    ST_FILL
  } seq_state_t;

endpackage : irq_ctrl_pkg

// ### design/pin_irq_detect.sv
// External interrupt pin: synchroniser, edge/level detection and wake path
`timescale 1ns/1ps
module pin_irq_detect
  import irq_ctrl_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic pin_irq_enable_i,
  input  wire logic pin_irq_edge_select_i,
  input  wire logic pin_irq_detect_mode_i,
  input  wire logic pin_irq_interrupt_enable_i,
  input  wire logic pulldown_select_i,
  input  wire logic flag_clear_i,
  input  wire logic stop_mode_i,
  output logic      pin_irq_flag_o,
  output logic      request_o,
  output logic      wake_o,
  output logic      pull_up_en_o,
  output logic      pull_down_en_o,
  output logic      pin_level_o
);

  // ==========================================================================
  // Synchroniser and flag
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       level_r;
  logic       level_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       assert_now;
  logic       assert_prev;

  always_comb begin
    sync_nxt  = {sync_r[1:0], pin_i};
    // A change is accepted only once the second and third stages agree
    level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
    assert_now  = (level_nxt == pin_irq_edge_select_i);
    assert_prev = (level_r == pin_irq_edge_select_i);
    flag_nxt = flag_r;
    if (flag_clear_i) begin
      flag_nxt = 1'b0;
    end
    if (pin_irq_enable_i) begin
      if (assert_now && !assert_prev) begin
        flag_nxt = 1'b1;
      end
      // Level mode holds the flag while the pin stays asserted
      if (pin_irq_detect_mode_i && assert_now) begin
        flag_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_r  <= 3'h7;
      level_r <= 1'b1;
      flag_r  <= 1'b0;
    end else begin
      sync_r  <= sync_nxt;
      level_r <= level_nxt;
      flag_r  <= flag_nxt;
    end
  end

  assign pin_irq_flag_o = flag_r;
  assign request_o      = flag_r && pin_irq_interrupt_enable_i;
  assign pin_level_o    = level_r;
  // Clockless path: stop mode has no edges to sample with
  assign wake_o = stop_mode_i && pin_irq_enable_i &&
                  (pin_i == pin_irq_edge_select_i);
  assign pull_down_en_o = pin_irq_enable_i && pin_irq_edge_select_i &&
                          pulldown_select_i;
  assign pull_up_en_o   = pin_irq_enable_i && !pull_down_en_o;

endmodule : pin_irq_detect

// ### design/vector_priority.sv
// Picks the highest-priority (lowest-numbered) pending vector
`timescale 1ns/1ps
module vector_priority
  import irq_ctrl_pkg::*;
#(
  parameter int N = VEC_COUNT
) (
  input  wire logic [N-1:0]         pending_i,
  output logic                      found_o,
  output logic [VEC_NUM_W-1:0]      number_o
);

  function automatic logic [VEC_NUM_W-1:0] lowest_set(
    input logic [N-1:0] v
  );
    logic [VEC_NUM_W-1:0] n;
    n = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = VEC_NUM_W'(i);
      end
    end
    return n;
  endfunction : lowest_set

  assign found_o  = |pending_i;
  assign number_o = lowest_set(pending_i);

endmodule : vector_priority

// ### design/irq_pin_and_vector_control.sv
// Interrupt entry/return sequencer with pin detection and vector selection
`timescale 1ns/1ps
module irq_pin_and_vector_control
  import irq_ctrl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // External pin
  input  wire logic        pin_i,
  input  wire logic        pin_irq_enable_i,
  input  wire logic        pin_irq_edge_select_i,
  input  wire logic        pin_irq_detect_mode_i,
  input  wire logic        pin_irq_interrupt_enable_i,
  input  wire logic        pulldown_select_i,
  input  wire logic        pin_irq_flag_clear_i,
  input  wire logic        stop_mode_i,
  output logic             pin_irq_flag_o,
  output logic             wake_o,
  output logic             pull_up_en_o,
  output logic             pull_down_en_o,
  output logic             pin_level_o,
  // Peripheral flags and local enables, indexed by vector number
  input  wire logic [31:0] src_flag_i,
  input  wire logic [31:0] src_enable_i,
  // CPU core
  input  wire logic        instr_done_i,
  input  wire logic        return_from_interrupt_i,
  input  wire logic [15:0] pc_next_i,
  input  wire logic [7:0]  index_i,
  input  wire logic [7:0]  accum_i,
  input  wire logic [7:0]  condition_code_register_i,
  input  wire logic        sp_load_i,
  input  wire logic [15:0] sp_value_i,
  input  wire logic        mask_load_i,
  input  wire logic        mask_value_i,
  output logic [15:0]      sp_o,
  output logic             interrupt_mask_o,
  output logic             irq_pending_o,
  output logic             busy_o,
  output logic [4:0]       active_vector_o,
  output logic             entry_done_o,
  output logic             return_done_o,
  output logic [15:0]      pc_o,
  output logic [7:0]       index_o,
  output logic [7:0]       accum_o,
  output logic [7:0]       condition_code_register_o,
  output logic [23:0]      queue_o,
  // Memory port: reads return data in the same cycle
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             mem_we_o,
  output logic             mem_re_o,
  input  wire logic [7:0]  mem_rdata_i
);

  // ==========================================================================
  // Pin detection and request gating
  logic        pin_request;
  logic [31:0] pending;
  logic        found;
  logic [4:0]  best_vec;

  pin_irq_detect pin_irq_detect_inst (
    .sys_clk_i                  (sys_clk_i),
    .rst_i                      (rst_i),
    .pin_i                      (pin_i),
    .pin_irq_enable_i           (pin_irq_enable_i),
    .pin_irq_edge_select_i      (pin_irq_edge_select_i),
    .pin_irq_detect_mode_i      (pin_irq_detect_mode_i),
    .pin_irq_interrupt_enable_i (pin_irq_interrupt_enable_i),
    .pulldown_select_i          (pulldown_select_i),
    .flag_clear_i               (pin_irq_flag_clear_i),
    .stop_mode_i                (stop_mode_i),
    .pin_irq_flag_o             (pin_irq_flag_o),
    .request_o                  (pin_request),
    .wake_o                     (wake_o),
    .pull_up_en_o               (pull_up_en_o),
    .pull_down_en_o             (pull_down_en_o),
    .pin_level_o                (pin_level_o)
  );

  always_comb begin
    pending = src_flag_i & src_enable_i & VEC_USABLE_MASK;
    // The pin's own gated request replaces the generic slot
    pending[VEC_PIN] = pin_request;
  end

  vector_priority #(
    .N (VEC_COUNT)
  ) vector_priority_inst (
    .pending_i (pending),
    .found_o   (found),
    .number_o  (best_vec)
  );

  // Vector n high byte lives at top minus 2n; low byte one above
  function automatic logic [15:0] vector_addr(input logic [4:0] n);
    return VEC_TOP_ADDR - {10'h000, n, 1'b0};
  endfunction : vector_addr

  // ==========================================================================
  // Sequencer
  seq_state_t  state_r;
  seq_state_t  state_nxt;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic        mask_r;
  logic        mask_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  x_r;
  logic [7:0]  x_nxt;
  logic [7:0]  a_r;
  logic [7:0]  a_nxt;
  logic [7:0]  ccr_r;
  logic [7:0]  ccr_nxt;
  logic [4:0]  vec_r;
  logic [4:0]  vec_nxt;
  logic [1:0]  fill_r;
  logic [1:0]  fill_nxt;
  logic [23:0] queue_r;
  logic [23:0] queue_nxt;
  logic        from_return_r;
  logic        from_return_nxt;
  logic        entry_done_r;
  logic        entry_done_nxt;
  logic        return_done_r;
  logic        return_done_nxt;
  logic [15:0] sp_up;

  always_comb begin
    state_nxt       = state_r;
    sp_nxt          = sp_r;
    mask_nxt        = mask_r;
    pc_nxt          = pc_r;
    x_nxt           = x_r;
    a_nxt           = a_r;
    ccr_nxt         = ccr_r;
    vec_nxt         = vec_r;
    fill_nxt        = fill_r;
    queue_nxt       = queue_r;
    from_return_nxt = from_return_r;
    entry_done_nxt  = 1'b0;
    return_done_nxt = 1'b0;
    sp_up           = sp_r + 16'h0001;
    mem_addr_o      = 16'h0000;
    mem_wdata_o     = 8'h00;
    mem_we_o        = 1'b0;
    mem_re_o        = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (sp_load_i) begin
          sp_nxt = sp_value_i;
        end
        if (mask_load_i) begin
          mask_nxt = mask_value_i;
        end
        if (return_from_interrupt_i) begin
          state_nxt = ST_POP_CCR;
        end else if (instr_done_i && !mask_r && found) begin
          // Snapshot so the core may move on while the frame is written
          pc_nxt    = pc_next_i;
          x_nxt     = index_i;
          a_nxt     = accum_i;
          ccr_nxt   = condition_code_register_i;
          ccr_nxt[CCR_MASK_BIT] = mask_r;
          state_nxt = ST_PUSH_PCL;
        end
      end
      ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_X, ST_PUSH_A, ST_PUSH_CCR: begin
        mem_we_o   = 1'b1;
        mem_addr_o = sp_r;
        sp_nxt     = sp_r - 16'h0001;
        case (state_r)
          ST_PUSH_PCL: begin
            mem_wdata_o = pc_r[7:0];
            state_nxt   = ST_PUSH_PCH;
          end
          ST_PUSH_PCH: begin
            mem_wdata_o = pc_r[15:8];
            state_nxt   = ST_PUSH_X;
          end
          ST_PUSH_X: begin
            mem_wdata_o = x_r;
            state_nxt   = ST_PUSH_A;
          end
          ST_PUSH_A: begin
            mem_wdata_o = a_r;
            state_nxt   = ST_PUSH_CCR;
          end
          default: begin
            mem_wdata_o = ccr_r;
            state_nxt   = ST_VEC_HI;
          end
        endcase
      end
      ST_VEC_HI: begin
        mask_nxt   = 1'b1;
        // Priority is resolved here, so a late higher request still wins
        vec_nxt    = found ? best_vec : vec_r;
        mem_re_o   = 1'b1;
        mem_addr_o = vector_addr(vec_nxt);
        pc_nxt[15:8] = mem_rdata_i;
        state_nxt  = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        mem_re_o   = 1'b1;
        mem_addr_o = vector_addr(vec_r) + 16'h0001;
        pc_nxt[7:0] = mem_rdata_i;
        from_return_nxt = 1'b0;
        fill_nxt   = 2'h0;
        state_nxt  = ST_FILL;
      end
      ST_POP_CCR, ST_POP_A, ST_POP_X, ST_POP_PCH, ST_POP_PCL: begin
        mem_re_o   = 1'b1;
        mem_addr_o = sp_up;
        sp_nxt     = sp_up;
        case (state_r)
          ST_POP_CCR: begin
            ccr_nxt   = mem_rdata_i;
            mask_nxt  = mem_rdata_i[CCR_MASK_BIT];
            state_nxt = ST_POP_A;
          end
          ST_POP_A: begin
            a_nxt     = mem_rdata_i;
            state_nxt = ST_POP_X;
          end
          ST_POP_X: begin
            x_nxt     = mem_rdata_i;
            state_nxt = ST_POP_PCH;
          end
          ST_POP_PCH: begin
            pc_nxt[15:8] = mem_rdata_i;
            state_nxt    = ST_POP_PCL;
          end
          default: begin
            pc_nxt[7:0]     = mem_rdata_i;
            from_return_nxt = 1'b1;
            fill_nxt        = 2'h0;
            state_nxt       = ST_FILL;
          end
        endcase
      end
      ST_FILL: begin
        mem_re_o   = 1'b1;
        mem_addr_o = pc_r + {14'h0000, fill_r};
        queue_nxt  = {queue_r[15:0], mem_rdata_i};
        fill_nxt   = fill_r + 2'h1;
        if (fill_nxt == FILL_BYTES) begin
          state_nxt       = ST_IDLE;
          entry_done_nxt  = !from_return_r;
          return_done_nxt = from_return_r;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r       <= ST_IDLE;
      sp_r          <= SP_RESET;
      mask_r        <= 1'b1;
      pc_r          <= 16'h0000;
      x_r           <= 8'h00;
      a_r           <= 8'h00;
      ccr_r         <= 8'h00;
      vec_r         <= VEC_RESET;
      fill_r        <= 2'h0;
      queue_r       <= 24'h000000;
      from_return_r <= 1'b0;
      entry_done_r  <= 1'b0;
      return_done_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      sp_r          <= sp_nxt;
      mask_r        <= mask_nxt;
      pc_r          <= pc_nxt;
      x_r           <= x_nxt;
      a_r           <= a_nxt;
      ccr_r         <= ccr_nxt;
      vec_r         <= vec_nxt;
      fill_r        <= fill_nxt;
      queue_r       <= queue_nxt;
      from_return_r <= from_return_nxt;
      entry_done_r  <= entry_done_nxt;
      return_done_r <= return_done_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign sp_o                      = sp_r;
  assign interrupt_mask_o          = mask_r;
  assign irq_pending_o             = found;
  assign busy_o                    = (state_r != ST_IDLE);
  assign active_vector_o           = vec_r;
  assign entry_done_o              = entry_done_r;
  assign return_done_o             = return_done_r;
  assign pc_o                      = pc_r;
  assign index_o                   = x_r;
  assign accum_o                   = a_r;
  assign condition_code_register_o = ccr_r;
  assign queue_o                   = queue_r;

endmodule : irq_pin_and_vector_control

// ### tb/irq_pin_and_vector_control_props.sv
// Concurrent checks on the ports of the interrupt controller top level
`timescale 1ns/1ps
module irq_ctrl_props
  import irq_ctrl_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        pin_i,
  input wire logic        pin_irq_enable_i,
  input wire logic        pin_irq_edge_select_i,
  input wire logic        pin_irq_detect_mode_i,
  input wire logic        pin_irq_interrupt_enable_i,
  input wire logic        stop_mode_i,
  input wire logic        pin_irq_flag_o,
  input wire logic        wake_o,
  input wire logic        pin_level_o,
  input wire logic [31:0] src_flag_i,
  input wire logic [31:0] src_enable_i,
  input wire logic        return_from_interrupt_i,
  input wire logic [15:0] sp_o,
  input wire logic        interrupt_mask_o,
  input wire logic        irq_pending_o,
  input wire logic        busy_o,
  input wire logic [4:0]  active_vector_o,
  input wire logic        entry_done_o,
  input wire logic        return_done_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_we_o,
  input wire logic        mem_re_o,
  input wire logic [7:0]  mem_rdata_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Stack frame
  a_reset_mask_set: assert property ($fell(rst_i) |-> interrupt_mask_o
    && sp_o == SP_RESET) else $error("mask or sp wrong after reset");
  a_push_five: assert property ($rose(mem_we_o) |-> mem_we_o[*5]
    ##1 !mem_we_o) else $error("entry did not push five bytes");
  a_push_descend: assert property (mem_we_o && $past(mem_we_o)
    |-> mem_addr_o == $past(mem_addr_o) - 16'h1)
    else $error("push addresses do not descend");
  a_entry_sp: assert property (entry_done_o
    |-> sp_o == $past(sp_o, 11) - 16'h5) else $error("sp wrong after entry");
  a_return_sp: assert property (return_done_o
    |-> sp_o == $past(sp_o, 9) + 16'h5) else $error("sp wrong after return");
  a_vector_fetch: assert property (entry_done_o |->
    $past(mem_addr_o, 5) == 16'hfffe - {10'h0, active_vector_o, 1'b0}
    && pc_o == {$past(mem_rdata_i, 5), $past(mem_rdata_i, 4)})
    else $error("vector fetch wrong");
  a_refill_three: assert property (return_done_o |->
    $past(mem_re_o, 3) && $past(mem_addr_o, 3) == pc_o
    && $past(mem_addr_o, 1) == pc_o + 16'h2) else $error("refill wrong");
  a_mask_blocks: assert property (interrupt_mask_o && !busy_o
    && !return_from_interrupt_i |=> !busy_o) else $error("masked entry");
  a_entry_sets_mask: assert property (entry_done_o
    |-> interrupt_mask_o) else $error("mask clear after entry");

  // ==========================================================================
  // Request gating and pin
  a_request_gate: assert property (irq_pending_o ==
    (|(src_flag_i & src_enable_i & VEC_USABLE_MASK & 32'hffff_fffb)
    || (pin_irq_flag_o && pin_irq_interrupt_enable_i)))
    else $error("request gating wrong");
  a_level_holds: assert property (pin_irq_enable_i
    && pin_irq_detect_mode_i
    ##1 pin_level_o == $past(pin_irq_edge_select_i) |-> pin_irq_flag_o)
    else $error("flag cleared while level asserted");
  a_pin_off_quiet: assert property (!pin_irq_enable_i
    && !pin_irq_flag_o |=> !pin_irq_flag_o) else $error("disabled pin set");
  a_edge_sets_flag: assert property ($past(pin_irq_enable_i)
    && $changed(pin_level_o)
    && pin_level_o == $past(pin_irq_edge_select_i) |-> pin_irq_flag_o)
    else $error("edge did not set flag");
  a_wake_async: assert property (wake_o == (stop_mode_i
    && pin_irq_enable_i && pin_i == pin_irq_edge_select_i))
    else $error("wake path wrong");

  c_entry: cover property (entry_done_o);
  c_return: cover property (return_done_o);
  c_level: cover property (pin_irq_detect_mode_i && pin_irq_flag_o);
endmodule : irq_ctrl_props

bind irq_pin_and_vector_control irq_ctrl_props irq_ctrl_props_inst (
  .sys_clk_i, .rst_i, .pin_i, .pin_irq_enable_i, .pin_irq_edge_select_i,
  .pin_irq_detect_mode_i, .pin_irq_interrupt_enable_i, .stop_mode_i,
  .pin_irq_flag_o, .wake_o, .pin_level_o, .src_flag_i, .src_enable_i,
  .return_from_interrupt_i, .sp_o, .interrupt_mask_o, .irq_pending_o,
  .busy_o, .active_vector_o, .entry_done_o, .return_done_o, .pc_o,
  .mem_addr_o, .mem_we_o, .mem_re_o, .mem_rdata_i);

// ### tb/cpu_mem_model.sv
// Behavioural CPU-side memory: same-cycle reads, clocked writes
`timescale 1ns/1ps
module cpu_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        mem_we_i,
  input  wire logic        mem_re_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'h00;

  // Idle bus shows the inverse of the last byte, so stale data cannot pass
  always_comb mem_rdata_o = mem_re_i ? mem[mem_addr_i] : ~last_r;

  always @(posedge sys_clk_i) begin
    if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
    if (mem_re_i) last_r <= mem[mem_addr_i];
  end
endmodule : cpu_mem_model

// ### tb/test_irq_pin_and_vector_control.sv
// Self-checking bench for the interrupt pin and vector controller
`timescale 1ns/1ps
module test_irq_pin_and_vector_control;
  import irq_ctrl_pkg::*;
  logic        sys_clk_i, rst_i, pin_i, pin_irq_enable_i, stop_mode_i;
  logic        pin_irq_edge_select_i, pin_irq_detect_mode_i, wake_o;
  logic        pin_irq_interrupt_enable_i, pulldown_select_i, busy_o;
  logic        pin_irq_flag_clear_i, pin_irq_flag_o, pull_up_en_o;
  logic        pull_down_en_o, pin_level_o, instr_done_i, sp_load_i;
  logic        return_from_interrupt_i, mask_load_i, mask_value_i;
  logic        interrupt_mask_o, irq_pending_o, entry_done_o;
  logic        return_done_o, mem_we_o, mem_re_o;
  logic [31:0] src_flag_i, src_enable_i;
  logic [15:0] pc_next_i, sp_value_i, sp_o, pc_o, mem_addr_o;
  logic [7:0]  index_i, accum_i, condition_code_register_i, index_o;
  logic [7:0]  accum_o, condition_code_register_o, mem_wdata_o, mem_rdata_i;
  logic [4:0]  active_vector_o;
  logic [23:0] queue_o;
  int          fails, total_checks;

  irq_pin_and_vector_control irq_pin_and_vector_control_inst (.*);
  cpu_mem_model cpu_mem_model_inst (.sys_clk_i, .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_we_i(mem_we_o), .mem_re_i(mem_re_o),
    .mem_rdata_o(mem_rdata_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  function automatic logic [7:0] m(input logic [15:0] a);
    return cpu_mem_model_inst.mem[a];
  endfunction : m

  // Lowest-numbered usable vector other than the pin's (2) with flag and enable both set
  function automatic logic [4:0] exp_vec(input logic [31:0] f, e);
    exp_vec = 5'h00;
    for (int i = 25; i >= 1; i--)
      if (f[i] && e[i] && i != 2) exp_vec = 5'(i);
  endfunction : exp_vec

  task automatic wait_pulse(input bit ret);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (!(ret ? return_done_o : entry_done_o) && n < 40);
    check("completion", 32'(n < 40), 1);
  endtask : wait_pulse

  task automatic clear_flag;
    @(posedge sys_clk_i);
    pin_irq_flag_clear_i <= 1'b1;
    @(posedge sys_clk_i);
    pin_irq_flag_clear_i <= 1'b0;
    tick(1);
  endtask : clear_flag

  // ==========================================================================
  // Scenarios
  task automatic run_entry(input int v);
    logic [15:0] sp, pc, va;
    logic [31:0] fl, en;
    logic [7:0]  cc, x, a;
    sp = 16'h0100 + 16'($urandom_range(8, 200));
    pc = 16'($urandom);
    cc = 8'($urandom);
    x = 8'($urandom);
    a = 8'($urandom);
    fl = $urandom | (32'h1 << v);
    en = ~((32'h1 << v) - 32'h1);
    @(posedge sys_clk_i);
    sp_load_i <= 1'b1;
    sp_value_i <= sp;
    src_flag_i <= fl;
    src_enable_i <= en;
    pc_next_i <= pc;
    index_i <= x;
    accum_i <= a;
    condition_code_register_i <= cc;
    // Mask first: the previous return left it clear
    mask_load_i <= 1'b1;
    mask_value_i <= 1'b1;
    @(posedge sys_clk_i);
    sp_load_i <= 1'b0;
    mask_load_i <= 1'b0;
    instr_done_i <= 1'b1;
    tick(3);
    check("busy_masked", busy_o, 0);
    check("pending", irq_pending_o, 1);
    @(posedge sys_clk_i);
    mask_load_i <= 1'b1;
    mask_value_i <= 1'b0;
    @(posedge sys_clk_i);
    mask_load_i <= 1'b0;
    wait_pulse(0);
    va = 16'hfffe - 16'(2 * exp_vec(fl, en));
    check("vector", active_vector_o, exp_vec(fl, en));
    check("push_pcl", m(sp), pc[7:0]);
    check("push_pch", m(sp - 16'h1), pc[15:8]);
    check("push_x", m(sp - 16'h2), x);
    check("push_a", m(sp - 16'h3), a);
    check("push_ccr", m(sp - 16'h4), {cc[7:4], 1'b0, cc[2:0]});
    check("sp_entry", sp_o, sp - 16'h5);
    check("pc_vector", pc_o, {m(va), m(va + 16'h1)});
    check("mask_entry", interrupt_mask_o, 1);
    @(posedge sys_clk_i);
    src_flag_i <= 32'h0;
    instr_done_i <= 1'b0;
    return_from_interrupt_i <= 1'b1;
    @(posedge sys_clk_i);
    return_from_interrupt_i <= 1'b0;
    wait_pulse(1);
    check("pc_ret", pc_o, pc);
    check("x_ret", index_o, x);
    check("a_ret", accum_o, a);
    check("ccr_ret", condition_code_register_o,
          {cc[7:4], 1'b0, cc[2:0]});
    check("mask_ret", interrupt_mask_o, 0);
    check("sp_ret", sp_o, sp);
    check("queue", queue_o, {m(pc), m(pc + 16'h1), m(pc + 16'h2)});
  endtask : run_entry

  task automatic pin_case(input logic es, md);
    logic ie, pd;
    ie = 1'($urandom);
    pd = 1'($urandom);
    @(posedge sys_clk_i);
    pin_irq_enable_i <= 1'b1;
    pin_irq_edge_select_i <= es;
    pin_irq_detect_mode_i <= md;
    pin_irq_interrupt_enable_i <= ie;
    pulldown_select_i <= pd;
    stop_mode_i <= md;
    pin_i <= ~es;
    tick(6);
    clear_flag();
    check("pull_down", pull_down_en_o, es && pd);
    check("pull_up", pull_up_en_o, !(es && pd));
    check("wake_idle", wake_o, 0);
    check("flag_idle", pin_irq_flag_o, 0);
    @(posedge sys_clk_i);
    pin_i <= es;
    tick(6);
    check("flag_edge", pin_irq_flag_o, 1);
    check("pin_level", pin_level_o, es);
    check("pin_request", irq_pending_o, ie);
    check("wake", wake_o, md);
    clear_flag();
    tick(1);
    check("flag_level", pin_irq_flag_o, md);
    @(posedge sys_clk_i);
    pin_i <= ~es;
    tick(6);
    clear_flag();
    check("flag_cleared", pin_irq_flag_o, 0);
  endtask : pin_case

  // ==========================================================================
  // Main sequence
  initial begin
    {pin_irq_enable_i, pin_irq_edge_select_i, pin_irq_detect_mode_i} = '0;
    {pin_irq_interrupt_enable_i, pulldown_select_i, stop_mode_i} = '0;
    {pin_irq_flag_clear_i, instr_done_i, return_from_interrupt_i} = '0;
    {sp_load_i, mask_load_i, mask_value_i} = '0;
    {src_flag_i, src_enable_i, pc_next_i, sp_value_i} = '0;
    {index_i, accum_i, condition_code_register_i} = '0;
    pin_i = 1'b1;
    rst_i = 1'b1;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'he731));
    for (int i = 0; i < 65536; i++) cpu_mem_model_inst.mem[i] = 8'($urandom);
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    tick(1);
    check("mask_reset", interrupt_mask_o, 1);
    check("sp_reset", sp_o, SP_RESET);
    check("pend_reset", irq_pending_o, 0);
    run_entry(1);
    run_entry(14);
    run_entry(25);
    for (int k = 0; k < 3; k++) run_entry(3 + $urandom_range(0, 22));
    for (int k = 0; k < 4; k++) pin_case(k[1], k[0]);
    @(posedge sys_clk_i);
    pin_irq_enable_i <= 1'b0;
    pin_i <= ~pin_irq_edge_select_i;
    tick(6);
    @(posedge sys_clk_i);
    pin_i <= pin_irq_edge_select_i;
    tick(6);
    check("pin_disabled", pin_irq_flag_o, 0);
    check("wake_disabled", wake_o, 0);
    check("pull_off", pull_up_en_o | pull_down_en_o, 0);
    test_done();
  end

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fails++;
    test_done();
  end
endmodule : test_irq_pin_and_vector_control
